// ==== core/rxcf_regs.v ====
// Receiver front-end configuration register bank with APB slave and control decode
//
// Behaviour
// - Single channel enabled: choice bit picks it
// - Both enabled, manual: choice bit picks framing
// - Demod mode and AM demod type select
// - Dynamic squelch starts 18.88 us after TX
// - Squelch ratio bit sets trigger level
// - Gain loop enable and pulse-limited mode
// - Gain algorithm preset or reset select
// - Gain loop ratio three or six
// - AM first stage gain coding
// - PM first stage gain coding
// - Low frequency input select
// - Low frequency split mode routing
// - Second stage gain fields, codes 0-A
// - Second stage window then stage reduction
// - Second stage applied on reset gain command
`include "rxcf_consts.vh"
module rxcf_regs (
    input  wire        i_sys_clk,
    input  wire        i_rst_b,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [31:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    input  wire        i_am_chan_en,
    input  wire        i_pm_chan_en,
    input  wire        i_manual_sel,
    input  wire        i_tx_active,
    input  wire        i_mrt_reached,
    input  wire        i_subcarrier_pulse,
    input  wire        i_rx_active,
    input  wire        i_reset_gain_cmd,
    output wire        o_am_chan_on,
    output wire        o_pm_chan_on,
    output wire        o_framing_from_pm,
    output wire        o_iq_demod,
    output wire        o_am_mixer,
    output wire        o_squelch_on,
    output wire        o_squelch_ratio_6_3,
    output wire        o_agc_run,
    output wire        o_agc_alg_reset,
    output wire        o_gain_loop_ratio,
    output wire [2:0]  o_am_first_stage_gain,
    output wire [2:0]  o_pm_first_stage_gain,
    output wire        o_am_first_boost,
    output wire        o_pm_first_boost,
    output wire        o_low_freq_input_select,
    output wire        o_receive_input_one_to_am,
    output wire        o_receive_input_two_to_pm,
    output wire [3:0]  o_am_later_stage_gain,
    output wire [3:0]  o_pm_later_stage_gain,
    output wire [2:0]  o_am_window_steps,
    output wire [2:0]  o_pm_window_steps,
    output wire [2:0]  o_am_stage_steps,
    output wire [2:0]  o_pm_stage_steps
);

    reg [7:0]  chan_filter_ff;
    reg [7:0]  demod_sq_ff;
    reg [7:0]  first_gain_ff;
    reg [7:0]  second_gain_ff;
    reg [7:0]  applied_gain_ff;
    reg [31:0] prdata_ff;
    reg        pready_ff;
    reg        pslverr_ff;
    reg [1:0]  tx_sync_ff;
    reg [1:0]  mrt_sync_ff;
    reg [1:0]  sub_sync_ff;
    reg [1:0]  rxa_sync_ff;
    reg        tx_prev_ff;
    reg        sub_prev_ff;
    reg [15:0] sq_cnt_ff;
    reg        sq_wait_ff;
    reg        squelch_ff;
    reg [3:0]  pulse_cnt_ff;
    reg        am_on_ff;
    reg        pm_on_ff;
    reg        frame_pm_ff;
    reg        agc_run_ff;
    reg [7:0]  idx;
    reg [31:0] nxt_prdata;
    reg        hit;

    wire access = i_psel && i_penable && !pready_ff;
    wire wr     = access && i_pwrite && hit;
    wire tx_end = tx_prev_ff && !tx_sync_ff[1];
    wire sub_rise = sub_sync_ff[1] && !sub_prev_ff;
    wire ch_pm  = chan_filter_ff[`RXCF_BIT_CH_CHOICE];

    // Word aligned decode of the byte address
    always @* begin
        idx = i_paddr[9:2];
        hit = (i_paddr[31:10] == 22'h000000) && (i_paddr[1:0] == 2'h0) &&
              ((idx >= `RXCF_IDX_CHANNEL_FILTER && idx <= `RXCF_IDX_SECOND_GAIN) ||
               idx == `RXCF_IDX_STATUS);
        nxt_prdata = 32'h00000000;
        case (idx)
            `RXCF_IDX_CHANNEL_FILTER: nxt_prdata = {24'h000000, chan_filter_ff};
            `RXCF_IDX_DEMOD_SQUELCH:  nxt_prdata = {24'h000000, demod_sq_ff};
            `RXCF_IDX_FIRST_GAIN:     nxt_prdata = {24'h000000, first_gain_ff};
            `RXCF_IDX_SECOND_GAIN:    nxt_prdata = {24'h000000, second_gain_ff};
            `RXCF_IDX_STATUS:         nxt_prdata = {20'h00000, squelch_ff, agc_run_ff,
                                                    frame_pm_ff, pm_on_ff,
                                                    applied_gain_ff};
            default:                  nxt_prdata = 32'h00000000;
        endcase
        if (!hit) begin
            nxt_prdata = 32'h00000000;
        end
    end

    // One wait state per access: ready is registered on the first penable edge
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= access;
            pslverr_ff <= access && (!hit || (i_pwrite && idx == `RXCF_IDX_STATUS));
            if (access && !i_pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // Status index is read-only; writes there are refused
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            chan_filter_ff  <= `RXCF_RST_CHANNEL_FILTER;
            demod_sq_ff     <= `RXCF_RST_DEMOD_SQUELCH;
            first_gain_ff   <= `RXCF_RST_FIRST_GAIN;
            second_gain_ff  <= `RXCF_RST_SECOND_GAIN;
            applied_gain_ff <= `RXCF_RST_SECOND_GAIN;
        end else begin
            if (wr && idx == `RXCF_IDX_CHANNEL_FILTER) begin
                chan_filter_ff <= i_pwdata[7:0];
            end
            if (wr && idx == `RXCF_IDX_DEMOD_SQUELCH) begin
                demod_sq_ff <= i_pwdata[7:0];
            end
            if (wr && idx == `RXCF_IDX_FIRST_GAIN) begin
                first_gain_ff <= i_pwdata[7:0];
            end
            if (wr && idx == `RXCF_IDX_SECOND_GAIN) begin
                second_gain_ff <= i_pwdata[7:0];
            end
            if (i_reset_gain_cmd) begin
                applied_gain_ff <= second_gain_ff;
            end
        end
    end

    // Pins from the analogue side pass two flip-flops
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            tx_sync_ff  <= 2'h0;
            mrt_sync_ff <= 2'h0;
            sub_sync_ff <= 2'h0;
            rxa_sync_ff <= 2'h0;
            tx_prev_ff  <= 1'b0;
            sub_prev_ff <= 1'b0;
        end else begin
            tx_sync_ff  <= {tx_sync_ff[0], i_tx_active};
            mrt_sync_ff <= {mrt_sync_ff[0], i_mrt_reached};
            sub_sync_ff <= {sub_sync_ff[0], i_subcarrier_pulse};
            rxa_sync_ff <= {rxa_sync_ff[0], i_rx_active};
            tx_prev_ff  <= tx_sync_ff[1];
            sub_prev_ff <= sub_sync_ff[1];
        end
    end

    // Squelch: delayed start after TX, stop at mask timer
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            sq_cnt_ff  <= 16'h0000;
            sq_wait_ff <= 1'b0;
            squelch_ff <= 1'b0;
        end else if (!demod_sq_ff[`RXCF_BIT_SQ_DYN] || tx_sync_ff[1]) begin
            sq_cnt_ff  <= 16'h0000;
            sq_wait_ff <= 1'b0;
            squelch_ff <= 1'b0;
        end else if (tx_end) begin
            sq_cnt_ff  <= 16'h0001;
            sq_wait_ff <= 1'b1;
        end else if (sq_wait_ff) begin
            if (sq_cnt_ff == `RXCF_SQ_DELAY_CYC) begin
                sq_wait_ff <= 1'b0;
                squelch_ff <= !mrt_sync_ff[1];
            end else begin
                sq_cnt_ff <= sq_cnt_ff + 16'h0001;
            end
        end else if (mrt_sync_ff[1]) begin
            squelch_ff <= 1'b0;
        end
    end

    // Gain loop: pulse-limited or whole receive period
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            pulse_cnt_ff <= 4'h0;
            agc_run_ff   <= 1'b0;
        end else begin
            if (!rxa_sync_ff[1]) begin
                pulse_cnt_ff <= 4'h0;
            end else if (sub_rise && pulse_cnt_ff != `RXCF_AGC_PULSES) begin
                pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
            end
            agc_run_ff <= demod_sq_ff[`RXCF_BIT_AGC_EN] && rxa_sync_ff[1] &&
                          (demod_sq_ff[`RXCF_BIT_AGC_MODE] ||
                           pulse_cnt_ff != `RXCF_AGC_PULSES);
        end
    end

    // Channel enables and framing source
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            am_on_ff    <= 1'b0;
            pm_on_ff    <= 1'b0;
            frame_pm_ff <= 1'b0;
        end else if (i_am_chan_en && i_pm_chan_en) begin
            am_on_ff    <= 1'b1;
            pm_on_ff    <= 1'b1;
            frame_pm_ff <= i_manual_sel ? ch_pm : frame_pm_ff;
        end else if (i_am_chan_en || i_pm_chan_en) begin
            am_on_ff    <= !ch_pm;
            pm_on_ff    <= ch_pm;
            frame_pm_ff <= ch_pm;
        end else begin
            am_on_ff    <= 1'b0;
            pm_on_ff    <= 1'b0;
            frame_pm_ff <= 1'b0;
        end
    end

    // Static decodes registered so every output leaves a flip-flop
    reg [5:0]  stat_ff;
    reg [8:0]  first_ff;
    reg [19:0] second_ff;
    wire [3:0] am_code = applied_gain_ff[7:4];
    wire [3:0] pm_code = applied_gain_ff[3:0];

    // Codes above A are clamped for the window and stage steps; the later stage gain outputs still carry them raw
    function [5:0] split_code;
        input [3:0] c;
        reg   [3:0] k;
        reg   [3:0] d;
        begin
            k = (c > `RXCF_CODE_MAX_SECOND) ? `RXCF_CODE_MAX_SECOND : c;
            d = k - `RXCF_CODE_WINDOW_MAX;
            if (k <= `RXCF_CODE_WINDOW_MAX) begin
                split_code = {k[2:0], 3'h0};
            end else begin
                split_code = {3'h4, d[2:0]};
            end
        end
    endfunction

    wire [5:0] am_split = split_code(am_code);
    wire [5:0] pm_split = split_code(pm_code);

    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            stat_ff   <= 6'h00;
            first_ff  <= 9'h000;
            second_ff <= 20'h00000;
        end else begin
            stat_ff <= {demod_sq_ff[`RXCF_BIT_DEMOD_MODE],
                        demod_sq_ff[`RXCF_BIT_AMD_MIXER],
                        demod_sq_ff[`RXCF_BIT_SQ_RATIO],
                        demod_sq_ff[`RXCF_BIT_AGC_ALG],
                        demod_sq_ff[`RXCF_BIT_AGC_RATIO],
                        first_gain_ff[`RXCF_BIT_LF_SEL]};
            first_ff <= {first_gain_ff[7:5], first_gain_ff[4:2],
                         first_gain_ff[7:5] == 3'h7, first_gain_ff[4:2] == 3'h7,
                         first_gain_ff[`RXCF_BIT_LF_SEL] &&
                         first_gain_ff[`RXCF_BIT_LF_SPLIT]};
            second_ff <= {am_code, pm_code, am_split, pm_split};
        end
    end

    assign o_prdata                = prdata_ff;
    assign o_pready                = pready_ff;
    assign o_pslverr               = pslverr_ff;
    assign o_am_chan_on            = am_on_ff;
    assign o_pm_chan_on            = pm_on_ff;
    assign o_framing_from_pm       = frame_pm_ff;
    assign o_squelch_on            = squelch_ff;
    assign o_agc_run               = agc_run_ff;
    assign o_iq_demod              = stat_ff[5];
    assign o_am_mixer              = stat_ff[4];
    assign o_squelch_ratio_6_3     = stat_ff[3];
    assign o_agc_alg_reset         = stat_ff[2];
    assign o_gain_loop_ratio       = stat_ff[1];
    assign o_low_freq_input_select = stat_ff[0];
    assign o_am_first_stage_gain   = first_ff[8:6];
    assign o_pm_first_stage_gain   = first_ff[5:3];
    assign o_am_first_boost        = first_ff[2];
    assign o_pm_first_boost        = first_ff[1];
    assign o_receive_input_one_to_am            = first_ff[0];
    assign o_receive_input_two_to_pm            = first_ff[0];
    assign o_am_later_stage_gain   = second_ff[19:16];
    assign o_pm_later_stage_gain   = second_ff[15:12];
    assign o_am_window_steps       = second_ff[11:9];
    assign o_am_stage_steps        = second_ff[8:6];
    assign o_pm_window_steps       = second_ff[5:3];
    assign o_pm_stage_steps        = second_ff[2:0];

endmodule

// ==== core/rxcf_consts.vh ====
// Offsets, field positions, reset values and timing counts of the receiver config bank
`ifndef RXCF_CONSTS_VH
`define RXCF_CONSTS_VH
`define RXCF_IDX_CHANNEL_FILTER   8'h0B
`define RXCF_IDX_DEMOD_SQUELCH    8'h0C
`define RXCF_IDX_FIRST_GAIN       8'h0D
`define RXCF_IDX_SECOND_GAIN      8'h0E
`define RXCF_IDX_CTRL             8'h10
`define RXCF_IDX_STATUS           8'h11
`define RXCF_RST_CHANNEL_FILTER   8'h00
`define RXCF_RST_DEMOD_SQUELCH    8'h2C
`define RXCF_RST_FIRST_GAIN       8'hD8
`define RXCF_RST_SECOND_GAIN      8'h00
`define RXCF_BIT_CH_CHOICE        7
`define RXCF_BIT_DEMOD_MODE       7
`define RXCF_BIT_AMD_MIXER        6
`define RXCF_BIT_SQ_DYN           5
`define RXCF_BIT_SQ_RATIO         4
`define RXCF_BIT_AGC_EN           3
`define RXCF_BIT_AGC_MODE         2
`define RXCF_BIT_AGC_ALG          1
`define RXCF_BIT_AGC_RATIO        0
`define RXCF_BIT_LF_SEL           1
`define RXCF_BIT_LF_SPLIT         0
`define RXCF_CODE_MAX_SECOND      4'hA
`define RXCF_CODE_WINDOW_MAX      4'h4
`define RXCF_SQ_DELAY_NS          18880
`define RXCF_CLK_PERIOD_NS        10
// Squelch delay in cycles of the 10 ns clock, sized for the 16-bit counter
`define RXCF_SQ_DELAY_CYC         16'h0760
`define RXCF_AGC_PULSES           4'h8
`endif

// ==== tb/rxcf_checker.sv ====
// Concurrent checks on the receiver config bank ports
module rxcf_checker (
    input wire       i_sys_clk,
    input wire       i_rst_b,
    input wire       i_psel,
    input wire       i_penable,
    input wire       i_am_chan_en,
    input wire       i_pm_chan_en,
    input wire       i_tx_active,
    input wire       i_reset_gain_cmd,
    input wire       o_pready,
    input wire       o_pslverr,
    input wire       o_am_chan_on,
    input wire       o_pm_chan_on,
    input wire       o_squelch_on,
    input wire [2:0] o_am_first_stage_gain,
    input wire       o_am_first_boost,
    input wire       o_low_freq_input_select,
    input wire       o_receive_input_one_to_am,
    input wire       o_receive_input_two_to_pm,
    input wire [3:0] o_am_later_stage_gain,
    input wire [2:0] o_am_window_steps,
    input wire [2:0] o_am_stage_steps
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);
    a_ready_after_access: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("no ready after access phase");
    a_ready_one_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    a_error_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("slave error without ready");
    // Two-cycle guard: decodes read zero just after reset release
    a_single_channel: assert property ($past(i_rst_b, 2) && (i_am_chan_en ^ i_pm_chan_en)
        |=> o_am_chan_on ^ o_pm_chan_on)
        else $error("single enable did not give exactly one channel");
    a_no_channel: assert property (!i_am_chan_en && !i_pm_chan_en
        |=> !o_am_chan_on && !o_pm_chan_on)
        else $error("channel on with no enable");
    a_boost_code: assert property (o_am_first_boost == (o_am_first_stage_gain == 3'h7))
        else $error("boost flag does not match code seven");
    a_split_route: assert property (o_receive_input_one_to_am |-> o_low_freq_input_select && o_receive_input_two_to_pm)
        else $error("split routing without low frequency input");
    a_window_clamp: assert property (o_am_later_stage_gain > 4'h4 ?
        (o_am_window_steps == 3'h4 && o_am_stage_steps == o_am_later_stage_gain[2:0] - 3'h4) :
        (o_am_window_steps == o_am_later_stage_gain[2:0] && o_am_stage_steps == 3'h0))
        else $error("window or stage steps wrong for applied code");
    a_later_on_cmd: assert property ($changed(o_am_later_stage_gain) |-> $past(i_reset_gain_cmd, 2))
        else $error("applied second gain changed without command");
    a_tx_quiet: assert property (i_tx_active [*5] |=> !o_squelch_on)
        else $error("squelch active during transmission");
endmodule

bind rxcf_regs rxcf_checker u_chk (.*);

// ==== tb/tb.sv ====
// Self-checking bench for the receiver config register bank
`include "rxcf_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_sys_clk, i_rst_b, i_psel, i_penable, i_pwrite, i_am_chan_en, i_pm_chan_en;
    logic        i_manual_sel, i_tx_active, i_mrt_reached, i_subcarrier_pulse, i_rx_active;
    logic        i_reset_gain_cmd;
    logic [31:0] i_paddr, i_pwdata, seed;
    wire  [31:0] o_prdata;
    wire         o_pready, o_pslverr, o_am_chan_on, o_pm_chan_on, o_framing_from_pm, o_iq_demod;
    wire         o_am_mixer, o_squelch_on, o_squelch_ratio_6_3, o_agc_run, o_agc_alg_reset;
    wire         o_gain_loop_ratio, o_am_first_boost, o_pm_first_boost, o_low_freq_input_select;
    wire         o_receive_input_one_to_am, o_receive_input_two_to_pm;
    wire  [2:0]  o_am_first_stage_gain, o_pm_first_stage_gain, o_am_window_steps;
    wire  [2:0]  o_pm_window_steps, o_am_stage_steps, o_pm_stage_steps;
    wire  [3:0]  o_am_later_stage_gain, o_pm_later_stage_gain;
    logic [33:0] expq[$], e;
    logic [9:0]  pa, pb;
    logic [7:0]  v;
    int          fails, tests_run, n;

    rxcf_regs u_dut (.*);

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge i_sys_clk);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Applied code, window steps, stage steps
    function automatic logic [9:0] gexp(input logic [3:0] g);
        return {g, (g > 4'h4) ? 3'h4 : g[2:0], (g > 4'h4) ? g[2:0] - 3'h4 : 3'h0};
    endfunction

    // Expectation queued at setup; the monitor pairs it with the ready pulse
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       input logic [31:0] exp, input logic err);
        @(posedge i_sys_clk);
        expq.push_back({!wr, err, exp});
        i_psel   <= 1'b1;
        i_pwrite <= wr;
        i_paddr  <= {22'h0, idx, 2'h0};
        i_pwdata <= wd;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 50 && o_pready !== 1'b1; n++)
            @(posedge i_sys_clk);
        if (n == 50) begin
            fails++;
            results();
        end
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    always @(posedge i_sys_clk) begin
        if (o_pready === 1'b1) begin
            e = (expq.size() > 0) ? expq.pop_front() : '1;
            check(32'(o_pslverr), 32'(e[32]));
            if (e[33])
                check(o_prdata, e[31:0]);
        end
    end

    initial begin
        {i_rst_b, i_psel, i_penable, i_pwrite, i_am_chan_en, i_pm_chan_en, i_manual_sel} = '0;
        {i_tx_active, i_mrt_reached, i_subcarrier_pulse, i_rx_active, i_reset_gain_cmd} = '0;
        i_paddr = '0;
        i_pwdata = '0;
        seed = 32'h618E;
        tick(5);
        i_rst_b <= 1'b1;
        apb(0, `RXCF_IDX_CHANNEL_FILTER, 0, `RXCF_RST_CHANNEL_FILTER, 0);
        apb(0, `RXCF_IDX_DEMOD_SQUELCH, 0, `RXCF_RST_DEMOD_SQUELCH, 0);
        apb(0, `RXCF_IDX_FIRST_GAIN, 0, `RXCF_RST_FIRST_GAIN, 0);
        apb(0, `RXCF_IDX_SECOND_GAIN, 0, `RXCF_RST_SECOND_GAIN, 0);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            v = (i == 3) ? (seed[7:0] & 8'h77) : seed[7:0];
            v = (i == 1) ? (v | 8'h40) : v;
            apb(1, `RXCF_IDX_CHANNEL_FILTER + 8'(i), {24'h0, v}, 0, 0);
            apb(0, `RXCF_IDX_CHANNEL_FILTER + 8'(i), 0, {24'h0, v}, 0);
        end
        apb(1, 8'h10, 32'hFF, 0, 1);
        apb(0, 8'h10, 0, 0, 1);
        $display("test registers done");
        for (int b = 0; b < 8; b++) begin
            // I/Q mode only with the mixer selected
            apb(1, `RXCF_IDX_DEMOD_SQUELCH, (32'h1 << b) | ((b == 7) ? 32'h40 : 32'h0), 0, 0);
            tick(2);
            check(32'({o_iq_demod, o_am_mixer, o_squelch_ratio_6_3, o_agc_alg_reset,
                o_gain_loop_ratio}), 32'({b == 7, b >= 6, b == 4, b == 1, b == 0}));
        end
        for (int k = 0; k < 16; k++) begin
            apb(1, `RXCF_IDX_CHANNEL_FILTER, {24'h0, k[0], 7'h0}, 0, 0);
            i_am_chan_en <= k[1];
            i_pm_chan_en <= k[2];
            i_manual_sel <= k[3];
            tick(3);
            if (k[1] ^ k[2])
                check(32'({o_am_chan_on, o_pm_chan_on}), 32'({!k[0], k[0]}));
            if (k[1] && k[2] && k[3])
                check(32'(o_framing_from_pm), 32'(k[0]));
        end
        for (int i = 0; i < 8; i++) begin
            apb(1, `RXCF_IDX_FIRST_GAIN, {24'h0, i[2:0], ~i[2:0], i[1:0]}, 0, 0);
            tick(2);
            check(32'({o_am_first_stage_gain, o_pm_first_stage_gain, o_am_first_boost,
                o_pm_first_boost}), 32'({i[2:0], ~i[2:0], i == 7, i == 0}));
            check(32'({o_low_freq_input_select, o_receive_input_one_to_am, o_receive_input_two_to_pm}),
                32'({i[1], i[1] & i[0], i[1] & i[0]}));
        end
        $display("test decodes done");
        pa = 10'h0;
        for (int c = 0; c <= 10; c++) begin
            apb(1, `RXCF_IDX_SECOND_GAIN, {24'h0, 4'(c), 4'hA - 4'(c)}, 0, 0);
            tick(2);
            check(32'(o_am_later_stage_gain), 32'(pa[9:6]));
            i_reset_gain_cmd <= 1'b1;
            tick(1);
            i_reset_gain_cmd <= 1'b0;
            tick(2);
            pa = gexp(4'(c));
            pb = gexp(4'hA - 4'(c));
            check(32'({o_am_later_stage_gain, o_am_window_steps, o_am_stage_steps}), 32'(pa));
            check(32'({o_pm_later_stage_gain, o_pm_window_steps, o_pm_stage_steps}), 32'(pb));
        end
        // Both channels, manual, PM chosen; applied gain A0; loops idle
        apb(0, `RXCF_IDX_STATUS, 0, 32'h3A0, 0);
        apb(1, `RXCF_IDX_STATUS, 32'hFF, 0, 1);
        $display("test second gain done");
        apb(1, `RXCF_IDX_DEMOD_SQUELCH, 32'h2C, 0, 0);
        i_tx_active <= 1'b1;
        tick(10);
        i_tx_active <= 1'b0;
        for (n = 0; n < 2100 && o_squelch_on !== 1'b1; n++)
            @(posedge i_sys_clk);
        check(32'(n >= 1888 && n <= 1895), 32'h1);
        i_mrt_reached <= 1'b1;
        tick(6);
        check(32'(o_squelch_on), 32'h0);
        i_mrt_reached <= 1'b0;
        apb(1, `RXCF_IDX_DEMOD_SQUELCH, 32'h0C, 0, 0);
        i_tx_active <= 1'b1;
        tick(10);
        i_tx_active <= 1'b0;
        n = 0;
        repeat (2000) begin
            @(posedge i_sys_clk);
            n += (o_squelch_on !== 1'b0);
        end
        check(n, 0);
        $display("test squelch done");
        apb(1, `RXCF_IDX_DEMOD_SQUELCH, 32'h08, 0, 0);
        i_rx_active <= 1'b1;
        for (int p = 0; p < 9; p++) begin
            tick(6);
            check(32'(o_agc_run), 32'(p < 8));
            i_subcarrier_pulse <= 1'b1;
            tick(3);
            i_subcarrier_pulse <= 1'b0;
        end
        apb(1, `RXCF_IDX_DEMOD_SQUELCH, 32'h0C, 0, 0);
        tick(3);
        check(32'(o_agc_run), 32'h1);
        apb(1, `RXCF_IDX_DEMOD_SQUELCH, 32'h04, 0, 0);
        tick(3);
        check(32'(o_agc_run), 32'h0);
        i_rx_active <= 1'b0;
        $display("test gain loop done");
        tick(5);
        results();
    end
endmodule
